// ### shared/rst_src_pkg.sv
// Constants, register map and carrier types of the reset source controller.
// Assumes a 40 MHz system clock and an AXI4-Lite register port.
package rst_src_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;

    // Times in nanoseconds
    localparam int unsigned LOW_SUPPLY_MIN_TIME_NS = 1_000;
    localparam int unsigned SOFT_RESET_DELAY_NS    = 2_000;
    localparam int unsigned RESET_PULSE_NS         = 100;
    localparam int unsigned CLK_PERIOD_NS          = 1_000_000_000 / CLK_HZ;

    // Least times round up to whole cycles
    localparam int unsigned LOW_SUPPLY_MIN_CYC =
        (LOW_SUPPLY_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SOFT_RESET_DELAY_CYC =
        (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_PULSE_CYC =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Byte addresses
    localparam logic [7:0] ADDR_THRESHOLD_SELECT = 8'h00;
    localparam logic [7:0] ADDR_RESET_FLAGS      = 8'h04;
    localparam logic [7:0] ADDR_WATCHDOG_CTRL    = 8'h08;
    localparam logic [7:0] ADDR_STATUS           = 8'h0C;

    // Threshold select codes
    localparam logic [7:0] THRESH_POR    = 8'h55;
    localparam logic [7:0] THRESH_CODE_B = 8'h33;
    localparam logic [7:0] THRESH_CODE_C = 8'h99;
    localparam logic [7:0] THRESH_CODE_D = 8'hAA;
    localparam logic [15:0] THRESHOLD_MV = 16'h0C4E;

    // Reset flag register bits
    localparam int unsigned FLAG_WDOG_BIT   = 0;
    localparam int unsigned FLAG_SELECT_BIT = 1;
    localparam int unsigned FLAG_SUPPLY_BIT = 2;
    localparam int unsigned FLAG_IDLE_BIT   = 7;

    // Watchdog control
    localparam logic [7:0] WDOG_CTRL_POR = 8'h53;
    localparam logic [4:0] WDOG_KEY_A    = 5'h0A;
    localparam logic [4:0] WDOG_KEY_B    = 5'h15;

    // Status bits
    localparam int unsigned STAT_PD_BIT = 0;
    localparam int unsigned STAT_TO_BIT = 1;

    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        RST_NONE    = 3'b001,
        RST_FULL    = 3'b010,
        RST_PARTIAL = 3'b100
    } reset_kind_t;

    typedef struct packed {
        logic       soft_pending;
        logic [1:0] soft_cause;
        logic [15:0] soft_cnt;
        logic [15:0] low_cnt;
        logic [7:0] pulse_cnt;
        reset_kind_t kind;
        logic [7:0] threshold_select;
        logic [7:0] wdog_ctrl;
        logic       supply_drop_flag;
        logic       select_corrupt_flag;
        logic       watchdog_ctrl_corrupt_flag;
        logic       idle_sysclk_keep;
        logic       timeout_flag;
        logic       powerdown_flag;
        logic       aw_seen;
        logic       w_seen;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic       full_reset;
        logic       partial_reset;
    } state_t;

endpackage

// ### hdl/reset_source_controller.sv
// Reset source controller: supply-drop, threshold-select guard, watchdog events.
// Assumes the supply comparator and watchdog counter sit outside; their levels
// and events arrive asynchronously and are synchronised here.
//
// Notes on behaviour
// - Sustained low supply causes reset, sets flag
// - Low supply not exceeding minimum time ignored
// - Four select codes valid, all same threshold
// - Invalid select: delayed reset, restore, flag
// - Supply-drop reset keeps select register contents
// - Select register powers on as 0x55
// - Bit 2 supply-drop flag, software clears
// - Bit 1 select-corrupt flag, software clears
// - Normal-mode timeout sets flag, full reset
// - Sleep timeout: partial reset, sets timeout flag
// - Timeout/powerdown flag values per reset type
// - Power-on resets core state to defaults
// - Timeout and corrupt-code full resets load defaults; partial clears PC
// - Bad watchdog key: delayed reset, bit 0
// - Powerdown flag: halt sets, clear/power clears
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module reset_source_controller
    import rst_src_pkg::*;
#(
    parameter int unsigned LOW_MIN_CYC  = LOW_SUPPLY_MIN_CYC,
    parameter int unsigned SOFT_DLY_CYC = SOFT_RESET_DELAY_CYC,
    parameter int unsigned PULSE_CYC    = RESET_PULSE_CYC
) (
    // Clock and reset (rst is power-on reset)
    input  wire logic        clk,
    input  wire logic        rst,
    // Monitored conditions from outside the clock domain
    input  wire logic        low_supply,
    input  wire logic        wdog_timeout,
    // Core events, same clock
    input  wire logic        halt_exec,
    input  wire logic        wdog_clear,
    // Reset outputs
    output logic             full_reset,
    output logic             partial_reset,
    output logic             timeout_flag,
    output logic             powerdown_flag,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // Counter widths bound the parameters; refuse what they cannot hold
    if (LOW_MIN_CYC < 1 || LOW_MIN_CYC > 65535 || SOFT_DLY_CYC < 1 || SOFT_DLY_CYC > 65535
        || PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad_param
        $error("reset_source_controller: counter parameter out of range");
    end

    localparam logic [15:0] LOW_MIN_W  = 16'(LOW_MIN_CYC);
    localparam logic [15:0] SOFT_DLY_W = 16'(SOFT_DLY_CYC);
    localparam logic [7:0]  PULSE_W    = 8'(PULSE_CYC);

    // Two-stage synchronisers; only stage two is read
    logic [1:0] low_sync_q;
    logic [1:0] tmo_sync_q;
    logic       tmo_prev_q;
    state_t     s_q;
    state_t     s_d;

    always_ff @(posedge clk) begin
        if (rst) begin
            low_sync_q <= 2'b00;
            tmo_sync_q <= 2'b00;
            tmo_prev_q <= 1'b0;
        end else begin
            low_sync_q <= {low_sync_q[0], low_supply};
            tmo_sync_q <= {tmo_sync_q[0], wdog_timeout};
            tmo_prev_q <= tmo_sync_q[1];
        end
    end

    wire logic low_lvl   = low_sync_q[1];
    wire logic tmo_event = tmo_sync_q[1] & ~tmo_prev_q;

    function automatic logic thresh_valid(input logic [7:0] v);
        thresh_valid = (v == THRESH_POR) || (v == THRESH_CODE_B) ||
                       (v == THRESH_CODE_C) || (v == THRESH_CODE_D);
    endfunction

    function automatic logic key_valid(input logic [4:0] k);
        key_valid = (k == WDOG_KEY_A) || (k == WDOG_KEY_B);
    endfunction

    logic        wr_go;
    logic        rd_go;
    logic        wr_bad;
    logic [31:0] rd_word;
    logic        rd_bad;
    logic [7:0]  wr_byte;
    logic        sw_clr_supply;
    logic        sw_clr_select;
    logic        sw_clr_wdog;
    logic        supply_trip;
    logic        soft_fire;

    always_comb begin
        s_d = s_q;
        wr_go = 1'b0;
        rd_go = 1'b0;
        wr_bad = 1'b0;
        rd_bad = 1'b0;
        rd_word = 32'h0000_0000;
        wr_byte = s_q.w_data[7:0];
        sw_clr_supply = 1'b0;
        sw_clr_select = 1'b0;
        sw_clr_wdog = 1'b0;
        supply_trip = 1'b0;
        soft_fire = 1'b0;

        s_d.full_reset = 1'b0;
        s_d.partial_reset = 1'b0;

        // Bus capture: address and data may come in either order
        if (s_axi_awvalid && !s_q.aw_seen && !s_q.bvalid) begin
            s_d.aw_seen = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_seen && !s_q.bvalid) begin
            s_d.w_seen = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // Write commit, one cycle after both halves are held
        if (s_q.aw_seen && s_q.w_seen && !s_q.bvalid) begin
            wr_go = 1'b1;
            s_d.aw_seen = 1'b0;
            s_d.w_seen = 1'b0;
            s_d.bvalid = 1'b1;
            unique case (s_q.aw_addr)
                ADDR_THRESHOLD_SELECT: begin
                    if (s_q.w_strb[0]) s_d.threshold_select = wr_byte;
                end
                ADDR_RESET_FLAGS: begin
                    if (s_q.w_strb[0]) begin
                        sw_clr_supply = !wr_byte[FLAG_SUPPLY_BIT];
                        sw_clr_select = !wr_byte[FLAG_SELECT_BIT];
                        sw_clr_wdog   = !wr_byte[FLAG_WDOG_BIT];
                        s_d.idle_sysclk_keep = wr_byte[FLAG_IDLE_BIT];
                    end
                end
                ADDR_WATCHDOG_CTRL: begin
                    if (s_q.w_strb[0]) s_d.wdog_ctrl = wr_byte;
                end
                ADDR_STATUS: ;
                default: wr_bad = 1'b1;
            endcase
            s_d.bresp = wr_bad ? AXI_SLVERR : AXI_OKAY;
        end

        // Read path
        if (s_axi_arvalid && !s_q.rvalid) begin
            rd_go = 1'b1;
            unique case (s_axi_araddr)
                ADDR_THRESHOLD_SELECT: rd_word = {24'h00_0000, s_q.threshold_select};
                ADDR_RESET_FLAGS: rd_word = {24'h00_0000, s_q.idle_sysclk_keep, 4'h0,
                                             s_q.supply_drop_flag, s_q.select_corrupt_flag,
                                             s_q.watchdog_ctrl_corrupt_flag};
                ADDR_WATCHDOG_CTRL: rd_word = {24'h00_0000, s_q.wdog_ctrl};
                ADDR_STATUS: rd_word = {THRESHOLD_MV, 14'h0000, s_q.timeout_flag, s_q.powerdown_flag};
                default: rd_bad = 1'b1;
            endcase
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_word;
            s_d.rresp = rd_bad ? AXI_SLVERR : AXI_OKAY;
        end

        // Supply-drop filter: only a low level lasting beyond the minimum trips
        if (low_lvl) begin
            if (s_q.low_cnt < LOW_MIN_W) begin
                s_d.low_cnt = s_q.low_cnt + 16'h0001;
            end else if (s_q.kind == RST_NONE) begin
                supply_trip = 1'b1;
            end
        end else begin
            s_d.low_cnt = 16'h0000;
        end

        // Corrupt-code detection arms the delayed soft reset
        if (!s_q.soft_pending && s_q.kind == RST_NONE) begin
            if (!thresh_valid(s_q.threshold_select)) begin
                s_d.soft_pending = 1'b1;
                s_d.soft_cause = 2'b01;
                s_d.soft_cnt = 16'h0000;
            end else if (!key_valid(s_q.wdog_ctrl[7:3])) begin
                s_d.soft_pending = 1'b1;
                s_d.soft_cause = 2'b10;
                s_d.soft_cnt = 16'h0000;
            end
        end else if (s_q.soft_pending) begin
            if (s_q.soft_cnt + 16'h0001 >= SOFT_DLY_W) begin
                soft_fire = 1'b1;
                s_d.soft_pending = 1'b0;
            end else begin
                s_d.soft_cnt = s_q.soft_cnt + 16'h0001;
            end
        end

        // Powerdown flag from core events
        if (wdog_clear) s_d.powerdown_flag = 1'b0;
        if (halt_exec) s_d.powerdown_flag = 1'b1;

        // Flag clears first so hardware sets below win
        if (sw_clr_supply) s_d.supply_drop_flag = 1'b0;
        if (sw_clr_select) s_d.select_corrupt_flag = 1'b0;
        if (sw_clr_wdog) s_d.watchdog_ctrl_corrupt_flag = 1'b0;

        // Reset sequencing, priority: supply drop, soft reset, watchdog
        if (s_q.kind != RST_NONE) begin
            if (s_q.pulse_cnt + 8'h01 >= PULSE_W) begin
                s_d.kind = RST_NONE;
            end else begin
                s_d.pulse_cnt = s_q.pulse_cnt + 8'h01;
                s_d.full_reset = (s_q.kind == RST_FULL);
                s_d.partial_reset = (s_q.kind == RST_PARTIAL);
            end
        end else if (supply_trip) begin
            s_d.kind = RST_FULL;
            s_d.pulse_cnt = 8'h00;
            s_d.full_reset = 1'b1;
            s_d.supply_drop_flag = 1'b1;
            s_d.soft_pending = 1'b0;
            s_d.wdog_ctrl = WDOG_CTRL_POR;
            // Select register and timeout/powerdown flags keep their values
        end else if (soft_fire) begin
            s_d.kind = RST_FULL;
            s_d.pulse_cnt = 8'h00;
            s_d.full_reset = 1'b1;
            s_d.wdog_ctrl = WDOG_CTRL_POR;
            s_d.threshold_select = THRESH_POR;
            if (s_q.soft_cause == 2'b01) s_d.select_corrupt_flag = 1'b1;
            else s_d.watchdog_ctrl_corrupt_flag = 1'b1;
        end else if (tmo_event) begin
            s_d.pulse_cnt = 8'h00;
            s_d.timeout_flag = 1'b1;
            if (s_q.powerdown_flag) begin
                // Sleep or idle: only PC and stack pointer are cleared
                s_d.kind = RST_PARTIAL;
                s_d.partial_reset = 1'b1;
                s_d.powerdown_flag = 1'b1;
            end else begin
                s_d.kind = RST_FULL;
                s_d.full_reset = 1'b1;
                s_d.wdog_ctrl = WDOG_CTRL_POR;
                s_d.threshold_select = THRESH_POR;
                s_d.soft_pending = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.kind <= RST_FULL;
            s_q.full_reset <= 1'b1;
            s_q.threshold_select <= THRESH_POR;
            s_q.wdog_ctrl <= WDOG_CTRL_POR;
            s_q.timeout_flag <= 1'b0;
            s_q.powerdown_flag <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Write channels are ready while their slot is empty and no write response is pending
    assign s_axi_awready  = !s_q.aw_seen && !s_q.bvalid;
    assign s_axi_wready   = !s_q.w_seen && !s_q.bvalid;
    assign s_axi_arready  = !s_q.rvalid;
    assign s_axi_bvalid   = s_q.bvalid;
    assign s_axi_bresp    = s_q.bresp;
    assign s_axi_rvalid   = s_q.rvalid;
    assign s_axi_rdata    = s_q.rdata;
    assign s_axi_rresp    = s_q.rresp;
    assign full_reset     = s_q.full_reset;
    assign partial_reset  = s_q.partial_reset;
    assign timeout_flag   = s_q.timeout_flag;
    assign powerdown_flag = s_q.powerdown_flag;

endmodule // reset_source_controller
`default_nettype wire

// ### dv/reset_source_checker.sv
// Concurrent checks on the reset source controller ports.
// Assumes binding to the top module; counts come from its parameters.
`timescale 1ns/100ps
`default_nettype none
module reset_source_checker #(
    parameter int unsigned LOW_MIN_CYC = 40,
    parameter int unsigned PULSE_CYC   = 4
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Events and reset outputs
    input wire logic        low_supply,
    input wire logic        halt_exec,
    input wire logic        wdog_clear,
    input wire logic        full_reset,
    input wire logic        partial_reset,
    input wire logic        timeout_flag,
    input wire logic        powerdown_flag,
    // Register bus
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready
);
    logic [7:0] pcnt_q;
    logic [7:0] lcnt_q;

    // Run lengths of the reset pulse and of the raw low-supply level
    always_ff @(posedge clk) begin
        if (rst) begin
            pcnt_q <= 8'h00;
            lcnt_q <= 8'h00;
        end else begin
            pcnt_q <= full_reset ? pcnt_q + 8'h01 : 8'h00;
            lcnt_q <= low_supply ? lcnt_q + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pulse_len: assert property (full_reset |-> pcnt_q < PULSE_CYC)
        else $error("full reset pulse too long");
    a_reset_excl: assert property (!(full_reset && partial_reset))
        else $error("full and partial reset together");
    // Slack covers the two-stage synchroniser and the trip register
    a_low_trip: assert property (lcnt_q == LOW_MIN_CYC + 3 |-> ##[0:8] full_reset)
        else $error("sustained low supply gave no reset");
    a_part_flags: assert property ($rose(partial_reset) |-> ##[0:2] (timeout_flag && powerdown_flag))
        else $error("sleep timeout flags wrong");
    a_halt_sets: assert property (halt_exec && !full_reset && !partial_reset |=> powerdown_flag)
        else $error("halt did not set powerdown");
    a_clear_pd: assert property (wdog_clear && !halt_exec && !full_reset && !partial_reset |=> !powerdown_flag)
        else $error("watchdog clear kept powerdown");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
endmodule // reset_source_checker

bind reset_source_controller reset_source_checker #(.LOW_MIN_CYC(LOW_MIN_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (
    .clk, .rst, .low_supply, .halt_exec, .wdog_clear, .full_reset, .partial_reset, .timeout_flag,
    .powerdown_flag, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// ### dv/reset_source_controller_tb.sv
// Register-bus driven testbench for the reset source controller.
// Assumes the package and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module reset_source_controller_tb;
    import rst_src_pkg::*;
    localparam int unsigned LOW_N   = 3;
    localparam int unsigned SOFT_N  = 4;
    localparam int unsigned PULSE_N = 2;
    logic        clk = 1'b0;
    logic        rst, low_supply, wdog_timeout, halt_exec, wdog_clear;
    logic        full_reset, partial_reset, timeout_flag, powerdown_flag;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        fr_prev = 1'b0, pr_prev = 1'b0;
    int          n_full = 0, n_part = 0, error_cnt = 0, total_checks = 0;
    logic [7:0]  codes [4] = '{THRESH_POR, THRESH_CODE_B, THRESH_CODE_C, THRESH_CODE_D};
    logic [4:0]  keys [2] = '{WDOG_KEY_A, WDOG_KEY_B};

    reset_source_controller #(.LOW_MIN_CYC(LOW_N), .SOFT_DLY_CYC(SOFT_N), .PULSE_CYC(PULSE_N)) u_reset_source_controller (
        .clk, .rst, .low_supply, .wdog_timeout, .halt_exec, .wdog_clear, .full_reset, .partial_reset,
        .timeout_flag, .powerdown_flag, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    always #12.5 clk = ~clk;

    // Count reset pulses after release; the power-on pulse is not counted
    always @(posedge clk) begin
        if (!rst && full_reset === 1'b1 && !fr_prev) n_full++;
        if (!rst && partial_reset === 1'b1 && !pr_prev) n_part++;
        fr_prev <= full_reset;
        pr_prev <= partial_reset;
    end

    function automatic logic [31:0] st(input logic t, input logic p);
        return {THRESHOLD_MV, 14'h0, t, p};
    endfunction

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic timed_out();
        error_cnt++;
        $display("Error at %0t: wait ran out", $time);
        wrap_up();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int i;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        s_axi_bready <= 1'b0;
        // Let an edge pass so a following call never reassigns bready in this step
        @(posedge clk);
        if (i == 40) timed_out();
    endtask

    task automatic rd(input logic [7:0] a);
        int i;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
        if (i == 40) timed_out();
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        check(d, e);
    endtask

    // Bounded wait for a reset count, then let the pulse finish
    task automatic wait_n(ref int c, input int e);
        int i;
        for (i = 0; i < 40 && c != e; i++) @(posedge clk);
        if (i == 40) timed_out();
        tick(PULSE_N + 2);
    endtask

    initial begin
        {rst, low_supply, wdog_timeout, halt_exec, wdog_clear} = 5'b10000;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        tick(6);
        rst <= 1'b0;
        tick(PULSE_N + 2);
        rchk(ADDR_THRESHOLD_SELECT, {24'h0, THRESH_POR});
        rchk(ADDR_RESET_FLAGS, 32'h0);
        rchk(ADDR_STATUS, st(1'b0, 1'b0));
        rchk(ADDR_WATCHDOG_CTRL, {24'h0, WDOG_CTRL_POR});
        rd(8'h10);
        check({30'h0, r}, {30'h0, AXI_SLVERR});
        $display("Power-on test done");
        foreach (codes[k]) begin
            wr(ADDR_THRESHOLD_SELECT, {24'h0, codes[k]});
            rchk(ADDR_THRESHOLD_SELECT, {24'h0, codes[k]});
        end
        low_supply <= 1'b1;
        tick(LOW_N);
        low_supply <= 1'b0;
        tick(SOFT_N + 10);
        check(n_full, 0);
        rchk(ADDR_RESET_FLAGS, 32'h0);
        // Long enough to trip, short enough that the synced level is gone when the pulse ends
        low_supply <= 1'b1;
        tick(LOW_N + 3);
        low_supply <= 1'b0;
        wait_n(n_full, 1);
        rchk(ADDR_RESET_FLAGS, 32'h4);
        rchk(ADDR_THRESHOLD_SELECT, {24'h0, THRESH_CODE_D});
        rchk(ADDR_STATUS, st(1'b0, 1'b0));
        wr(ADDR_RESET_FLAGS, 32'hFF);
        rchk(ADDR_RESET_FLAGS, 32'h84);
        wr(ADDR_RESET_FLAGS, 32'h0);
        rchk(ADDR_RESET_FLAGS, 32'h0);
        $display("Supply test done");
        wr(ADDR_THRESHOLD_SELECT, 32'h12);
        tick(SOFT_N - 1);
        check({31'h0, full_reset}, 32'h0);
        wait_n(n_full, 2);
        rchk(ADDR_THRESHOLD_SELECT, {24'h0, THRESH_POR});
        rchk(ADDR_RESET_FLAGS, 32'h2);
        wr(ADDR_RESET_FLAGS, 32'h0);
        foreach (keys[k]) begin
            wr(ADDR_WATCHDOG_CTRL, {24'h0, keys[k], 3'b011});
            rchk(ADDR_WATCHDOG_CTRL, {24'h0, keys[k], 3'b011});
        end
        wr(ADDR_WATCHDOG_CTRL, 32'h3);
        wait_n(n_full, 3);
        rchk(ADDR_WATCHDOG_CTRL, {24'h0, WDOG_CTRL_POR});
        rchk(ADDR_RESET_FLAGS, 32'h1);
        $display("Corrupt register test done");
        wr(ADDR_THRESHOLD_SELECT, {24'h0, THRESH_CODE_C});
        wdog_timeout <= 1'b1;
        wait_n(n_full, 4);
        wdog_timeout <= 1'b0;
        rchk(ADDR_STATUS, st(1'b1, 1'b0));
        rchk(ADDR_THRESHOLD_SELECT, {24'h0, THRESH_POR});
        halt_exec <= 1'b1;
        tick(1);
        halt_exec <= 1'b0;
        wr(ADDR_THRESHOLD_SELECT, {24'h0, THRESH_CODE_C});
        rchk(ADDR_STATUS, st(1'b1, 1'b1));
        wdog_timeout <= 1'b1;
        wait_n(n_part, 1);
        wdog_timeout <= 1'b0;
        check(n_full, 4);
        check({30'h0, timeout_flag, powerdown_flag}, 32'h3);
        rchk(ADDR_THRESHOLD_SELECT, {24'h0, THRESH_CODE_C});
        rchk(ADDR_STATUS, st(1'b1, 1'b1));
        {halt_exec, wdog_clear} <= 2'b11;
        tick(1);
        {halt_exec, wdog_clear} <= 2'b00;
        rchk(ADDR_STATUS, st(1'b1, 1'b1));
        wdog_clear <= 1'b1;
        tick(1);
        wdog_clear <= 1'b0;
        rchk(ADDR_STATUS, st(1'b1, 1'b0));
        $display("Timeout test done");
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(PULSE_N + 2);
        rchk(ADDR_STATUS, st(1'b0, 1'b0));
        rchk(ADDR_THRESHOLD_SELECT, {24'h0, THRESH_POR});
        $display("Second power-on test done");
        wrap_up();
    end
endmodule // reset_source_controller_tb
`default_nettype wire
